// ===== design/plc_checker.sv
/*
 * privilege level checker for one tile: current level, per-resource
 * minimum levels, checks on core requests, handler entry, ahb-lite regs.
 * assumes one core request per cycle on clk, inputs already on clk.
 */
// Added by the designer: register access over AHB-Lite and the register offsets.
//
// Behaviour
// - one minimum level, values 0 to 3, for every protected resource
// - tile holds a current level used in every comparison
// - action completes when minimum level is at most current level
// - otherwise fault before effect and dispatch to that kind's handler
// - on entry keep current level if high enough, else raise it
// - code at or above a minimum may move it anywhere up to own level
// - changing a higher minimum, or setting above own: violation, no change
// - each minimum reads back, guarded by that same minimum
// - writing one to the set register for level n loads n
// - set succeeds only if current level covers max of minimum and n
// - user and system message network access gated separately
// - levels strictly ordered, 3 holds all privileges of lower ones
// - entry loads handler address from base, type, level; saves pc
// - special reads, writes, return and illegal codes are checked
`timescale 1ns/1ps
module plc_checker #(
    parameter int RES_N = plc_pkg::RES_N
) (
    input wire logic clk, // core clock
    input wire logic reset_n, // async reset, active low
    // ------------------------------------------------------------------
    // core pipeline
    // ------------------------------------------------------------------
    input wire logic req_valid, // request present this cycle
    input wire logic [2:0] req_op, // operation code
    input wire logic [$clog2(RES_N)-1:0] req_res, // resource slot
    input wire logic [1:0] req_lvl, // target level for set or return
    input wire logic [31:0] req_data, // value written to a set register
    input wire logic [31:0] core_pc, // pc of the current instruction
    input wire logic irq_in, // interrupt pulse from outside
    output logic req_ok, // request allowed, comb
    output logic req_fault, // request faulted, comb
    output logic [31:0] rd_data, // readback of a minimum level
    output logic exc_valid, // handler entry pulse
    output logic [2:0] exc_type, // event type being entered
    output logic [31:0] exc_pc, // handler address
    output logic [31:0] saved_pc, // pc to resume at
    output logic [1:0] cur_level, // current level
    output logic irq, // unmasked status pending
    // ------------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------------
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write when high
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // always ready
    output logic hresp // always okay
);
    localparam int RES_W = $clog2(RES_N);
    localparam int EVT_N = plc_pkg::EVT_N;

    typedef struct packed {
        logic [RES_N-1:0][1:0] lvl;
        logic [1:0] cur;
        logic [1:0] net_en;
        logic [31:0] base;
        logic [EVT_N-1:0] stat;
        logic [EVT_N-1:0] mask;
        logic irq_pend;
        logic exc_v;
        logic [2:0] exc_t;
        logic [31:0] exc_pc;
        logic [31:0] sav_pc;
        logic [31:0] rd_data;
        logic wr_ph;
        logic [7:0] wa;
        logic [31:0] hrd;
    } plc_st_s;

    plc_st_s state_r;
    plc_st_s state_nxt;
    logic [1:0] lvl_res;
    logic [1:0] lvl_iret;
    logic [1:0] hl;
    logic [1:0] lvl_new;
    logic res_ok;
    logic tgt_ok;
    logic iret_ok;
    logic keep_ok;
    logic fault;
    logic take;
    logic net_hit;
    logic net_on;
    logic [2:0] ev;
    logic [2:0] ent;
    logic [31:0] rdv;

    // ------------------------------------------------------------------
    // level comparisons
    // ------------------------------------------------------------------
    // lookups from the held levels against the current one
    assign lvl_res = state_r.lvl[req_res];
    assign lvl_iret = state_r.lvl[plc_pkg::RES_IRET[RES_W-1:0]];
    assign hl = state_r.lvl[ent];

    plc_cmp #(.W(plc_pkg::LVL_W)) u_res (
        .need(lvl_res),
        .have(state_r.cur),
        .ok(res_ok)
    );
    plc_cmp #(.W(plc_pkg::LVL_W)) u_tgt (
        .need(req_lvl),
        .have(state_r.cur),
        .ok(tgt_ok)
    );
    plc_cmp #(.W(plc_pkg::LVL_W)) u_iret (
        .need(lvl_iret),
        .have(state_r.cur),
        .ok(iret_ok)
    );
    plc_cmp #(.W(plc_pkg::LVL_W)) u_evt (
        .need(hl),
        .have(state_r.cur),
        .ok(keep_ok)
    );

    // network selection, anything but the two message nets is illegal
    assign net_hit = (req_res == plc_pkg::RES_UNET[RES_W-1:0]) ||
                     (req_res == plc_pkg::RES_SNET[RES_W-1:0]);
    assign net_on = (req_res == plc_pkg::RES_SNET[RES_W-1:0]) ?
                    state_r.net_en[plc_pkg::NET_S] :
                    state_r.net_en[plc_pkg::NET_U];

    // ------------------------------------------------------------------
    // request check
    // ------------------------------------------------------------------
    // decided in the request cycle so the core can squash the action
    always_comb
    begin
        fault = 1'b0;
        ev = plc_pkg::EV_PROT;
        if (req_valid)
        begin
            case (req_op)
                plc_pkg::OP_ACT,
                plc_pkg::OP_RD:
                begin
                    fault = !res_ok;
                    ev = plc_pkg::EV_PROT;
                end
                plc_pkg::OP_SET:
                begin
                    fault = !(res_ok && tgt_ok);
                    ev = plc_pkg::EV_GPV;
                end
                plc_pkg::OP_NET:
                begin
                    fault = !(net_hit && net_on && res_ok);
                    ev = net_hit ? plc_pkg::EV_NET : plc_pkg::EV_ILL;
                end
                plc_pkg::OP_IRET:
                begin
                    fault = !(iret_ok && tgt_ok);
                    ev = plc_pkg::EV_PROT;
                end
                default:
                begin
                    fault = 1'b1;
                    ev = plc_pkg::EV_ILL;
                end
            endcase
        end
    end

    assign req_fault = fault;
    assign req_ok = req_valid && !fault;
    // an interrupt waits for a cycle with no request, so a return and
    // an entry never fight over the current level
    assign take = fault || (state_r.irq_pend && !req_valid);
    assign ent = fault ? ev : plc_pkg::EV_IRQ;
    // the handler runs at the raised level, so its vector carries that
    // level and not the bare event minimum
    assign lvl_new = keep_ok ? state_r.cur : hl;

    // ------------------------------------------------------------------
    // register read mux
    // ------------------------------------------------------------------
    always_comb
    begin
        rdv = 32'h0000_0000;
        case (haddr[7:0])
            plc_pkg::A_CTRL: rdv[1:0] = state_r.net_en;
            plc_pkg::A_BASE: rdv = state_r.base;
            plc_pkg::A_STAT: rdv[EVT_N-1:0] = state_r.stat;
            plc_pkg::A_MASK: rdv[EVT_N-1:0] = state_r.mask;
            plc_pkg::A_LVL: rdv[1:0] = state_r.cur;
            default: rdv = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    // bus writes come first so a same-cycle event set beats a clear
    always_comb
    begin
        state_nxt = state_r;
        state_nxt.exc_v = 1'b0;
        state_nxt.wr_ph = 1'b0;
        if (hsel && hready && htrans[1])
        begin
            state_nxt.wr_ph = hwrite;
            state_nxt.wa = haddr[7:0];
            state_nxt.hrd = hwrite ? state_r.hrd : rdv;
        end
        if (state_r.wr_ph)
        begin
            case (state_r.wa)
                plc_pkg::A_CTRL: state_nxt.net_en = hwdata[1:0];
                plc_pkg::A_BASE: state_nxt.base = hwdata;
                plc_pkg::A_STAT:
                    state_nxt.stat = state_r.stat & ~hwdata[EVT_N-1:0];
                plc_pkg::A_MASK: state_nxt.mask = hwdata[EVT_N-1:0];
                default: state_nxt.base = state_r.base;
            endcase
        end
        if (take)
        begin
            // entry: raise only, never lower
            state_nxt.cur = lvl_new;
            state_nxt.exc_v = 1'b1;
            state_nxt.exc_t = ent;
            state_nxt.exc_pc = {state_r.base[31:plc_pkg::VEC_TOP], ent,
                                lvl_new, plc_pkg::VEC_PAD};
            state_nxt.sav_pc = core_pc;
            state_nxt.stat[ent] = 1'b1;
            if (!fault)
            begin
                state_nxt.irq_pend = 1'b0;
            end
        end
        else if (req_valid)
        begin
            case (req_op)
                plc_pkg::OP_SET:
                begin
                    // any other value is ignored without a fault
                    if (req_data == plc_pkg::SET_ONE)
                    begin
                        state_nxt.lvl[req_res] = req_lvl;
                    end
                end
                plc_pkg::OP_RD:
                    state_nxt.rd_data = {30'h0000_0000, lvl_res};
                plc_pkg::OP_IRET:
                    state_nxt.cur = req_lvl;
                default: state_nxt.cur = state_r.cur;
            endcase
        end
        if (irq_in)
        begin
            state_nxt.irq_pend = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    // everything restricted until privileged code lowers it
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_r <= '0;
            state_r.lvl <= {RES_N{plc_pkg::LVL_MAX}};
            state_r.cur <= plc_pkg::LVL_MAX;
            state_r.net_en <= plc_pkg::CTRL_RST;
            state_r.base <= plc_pkg::BASE_RST;
            state_r.mask <= plc_pkg::MASK_RST;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign rd_data = state_r.rd_data;
    assign exc_valid = state_r.exc_v;
    assign exc_type = state_r.exc_t;
    assign exc_pc = state_r.exc_pc;
    assign saved_pc = state_r.sav_pc;
    assign cur_level = state_r.cur;
    assign irq = |(state_r.stat & state_r.mask);
    assign hrdata = state_r.hrd;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_fault;
        req_fault;
    endsequence
    sequence s_entry;
        exc_valid && saved_pc == $past(core_pc);
    endsequence

    act_grant_a: assert property (
        req_valid && req_op == plc_pkg::OP_ACT && lvl_res <= cur_level
        |-> req_ok)
        else $error("allowed action refused");
    act_fault_a: assert property (
        req_valid && req_op == plc_pkg::OP_ACT && lvl_res > cur_level
        |=> exc_valid && exc_type == plc_pkg::EV_PROT)
        else $error("denied action gave no protection entry");
    entry_raise_a: assert property (
        take |=> cur_level == (($past(hl) > $past(state_r.cur)) ?
                               $past(hl) : $past(state_r.cur)))
        else $error("entry level wrong");
    set_load_a: assert property (
        req_ok && req_op == plc_pkg::OP_SET &&
        req_data == plc_pkg::SET_ONE
        |=> state_r.lvl[$past(req_res)] == $past(req_lvl))
        else $error("set register did not load level");
    set_guard_a: assert property (
        req_valid && req_op == plc_pkg::OP_SET &&
        (lvl_res > cur_level || req_lvl > cur_level)
        |-> req_fault ##1 exc_type == plc_pkg::EV_GPV &&
            $stable(state_r.lvl))
        else $error("bad set not refused");
    read_back_a: assert property (
        req_ok && req_op == plc_pkg::OP_RD
        |=> rd_data[1:0] == $past(lvl_res))
        else $error("readback value wrong");
    net_gate_a: assert property (
        req_valid && req_op == plc_pkg::OP_NET && !net_on |-> req_fault)
        else $error("disabled network allowed");
    entry_pc_a: assert property (
        s_fault |=> s_entry ##0
        exc_pc[plc_pkg::VEC_LO+:2] == cur_level)
        else $error("handler address or saved pc wrong");
    illegal_op_a: assert property (
        req_valid && req_op == plc_pkg::OP_ILL
        |-> req_fault ##1 exc_type == plc_pkg::EV_ILL)
        else $error("illegal code not trapped");
endmodule

// ===== design/plc_cmp.sv
/*
 * level comparator: grants when the held level reaches the needed one.
 * assumes both operands come from flops or ports of the same clock.
 */
`timescale 1ns/1ps
module plc_cmp #(
    parameter int W = 2
) (
    input wire logic [W-1:0] need, // level that the resource demands
    input wire logic [W-1:0] have, // level the tile runs at
    output logic ok // high when have covers need
);
    // strict order, higher number holds all lower privileges
    assign ok = (have >= need);
endmodule

// ===== design/plc_pkg.sv
/*
 * shared constants for the privilege level checker: levels, resource
 * slots, operation and event codes, register offsets and reset values.
 * assumes a 32-bit ahb-lite register bus and a 32-bit program counter.
 */
package plc_pkg;
    // ------------------------------------------------------------------
    // levels and resources
    // ------------------------------------------------------------------
    localparam int LVL_W = 2;
    localparam logic [1:0] LVL_MAX = 2'h3;
    localparam int RES_N = 16;
    localparam int EVT_N = 5;
    // slots 0..EVT_N-1 hold the handler level of each event type
    localparam logic [3:0] RES_IRET = 4'h5;
    localparam logic [3:0] RES_UNET = 4'h6;
    localparam logic [3:0] RES_SNET = 4'h7;
    localparam logic [31:0] SET_ONE = 32'h0000_0001;

    // ------------------------------------------------------------------
    // core requests and events
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_ACT = 3'h0,
        OP_RD = 3'h1,
        OP_SET = 3'h3,
        OP_NET = 3'h2,
        OP_IRET = 3'h6,
        OP_ILL = 3'h7
    } plc_op_e;
    typedef enum logic [2:0] {
        EV_PROT = 3'h0,
        EV_GPV = 3'h1,
        EV_ILL = 3'h2,
        EV_NET = 3'h3,
        EV_IRQ = 3'h4
    } plc_evt_e;
    // handler address: base[31:11], event type, handler level, zeros
    localparam int VEC_TOP = 11;
    localparam logic [5:0] VEC_PAD = 6'h00;
    localparam int VEC_LO = 6;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_BASE = 8'h04;
    localparam logic [7:0] A_STAT = 8'h08;
    localparam logic [7:0] A_MASK = 8'h0C;
    localparam logic [7:0] A_LVL = 8'h10;
    localparam int NET_U = 0;
    localparam int NET_S = 1;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [31:0] BASE_RST = 32'h0000_0000;
    localparam logic [4:0] MASK_RST = 5'h00;
endpackage

// ===== verification/plc_core_model.sv
/*
 * model of the core pipeline side: presents one request for one cycle
 * and returns the same-cycle verdict of the checker.
 * assumes the checker answers combinationally within that cycle.
 */
`timescale 1ns/1ps
module plc_core_model (
    input wire logic clk, // core clock
    input wire logic req_ok, // verdict from the checker
    input wire logic req_fault, // fault from the checker
    output logic req_valid, // request present
    output logic [2:0] req_op, // operation code
    output logic [3:0] req_res, // resource slot
    output logic [1:0] req_lvl, // target level
    output logic [31:0] req_data, // set register value
    output logic [31:0] core_pc // pc of the request
);
    // ------------------------------------------------------------------
    // request driver
    // ------------------------------------------------------------------
    // idle lines start quiet; later they carry garbage between requests
    initial
    begin
        req_valid = 1'b0;
        req_op = 3'h0;
        req_res = 4'h0;
        req_lvl = 2'h0;
        req_data = 32'h0000_0000;
        core_pc = 32'h0000_0000;
    end

    // one request per call, verdict sampled mid-cycle once it settles
    task automatic issue(input logic [2:0] op, input logic [3:0] res,
        input logic [1:0] lvl, input logic [31:0] data,
        input logic [31:0] pc, output logic ok, output logic flt);
    begin
        @(posedge clk);
        req_valid <= 1'b1;
        req_op <= op;
        req_res <= res;
        req_lvl <= lvl;
        req_data <= data;
        core_pc <= pc;
        @(negedge clk);
        ok = req_ok;
        flt = req_fault;
        @(posedge clk);
        // inverted leftovers so a stale value is never mistaken for live
        req_valid <= 1'b0;
        req_op <= ~op;
        req_res <= ~res;
        req_lvl <= ~lvl;
        req_data <= ~data;
        core_pc <= ~pc;
    end
    endtask
endmodule

// ===== verification/tb_top.sv
/*
 * self-checking bench for the privilege level checker: an integer model
 * of levels, status and vectors is compared at every result.
 * assumes the design files and the core model are compiled first.
 */
`timescale 1ns/1ps
module tb_top;
    logic clk;
    logic reset_n;
    logic irq_in;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic req_valid;
    logic [2:0] req_op;
    logic [3:0] req_res;
    logic [1:0] req_lvl;
    logic [31:0] req_data;
    logic [31:0] core_pc;
    logic req_ok;
    logic req_fault;
    logic [31:0] rd_data;
    logic exc_valid;
    logic [2:0] exc_type;
    logic [31:0] exc_pc;
    logic [31:0] saved_pc;
    logic [1:0] cur_level;
    logic irq;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    int n_mismatch = 0;
    int checks_done = 0;
    int lvl[16];
    int cur;
    int ops[7] = '{0, 1, 2, 3, 4, 6, 7};
    logic [31:0] base;
    logic [31:0] stat;
    logic [31:0] mask;
    logic [31:0] ctrl;
    logic [31:0] rdv;

    // ------------------------------------------------------------------
    // design and core model
    // ------------------------------------------------------------------
    plc_checker dut_u (.clk, .reset_n, .req_valid, .req_op, .req_res,
        .req_lvl, .req_data, .core_pc, .irq_in, .req_ok, .req_fault,
        .rd_data, .exc_valid, .exc_type, .exc_pc, .saved_pc, .cur_level,
        .irq, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp);
    plc_core_model core_u (.clk, .req_ok, .req_fault, .req_valid, .req_op,
        .req_res, .req_lvl, .req_data, .core_pc);

    // 40 MHz core clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
    begin
        checks_done++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    end
    endtask

    task report_and_stop;
    begin
        if (n_mismatch == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask

    // single ahb-lite transfer; waits are cut only by the watchdog
    task automatic ahb(input logic wr, input logic [31:0] a,
        input logic [31:0] wd, output logic [31:0] rd);
    begin
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
    begin
        ahb(1'b1, a, d, x);
    end
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e,
        input string nm);
        logic [31:0] x;
    begin
        ahb(1'b0, a, 32'h0, x);
        chk(nm, e, x);
    end
    endtask

    // one core request checked against the level model
    task automatic step(input int op, input int res, input int n,
        input logic [31:0] d);
        logic ok;
        logic flt;
        logic [31:0] pc;
        int t;
    begin
        pc = $urandom;
        case (op)
            0, 1: t = (lvl[res] > cur) ? 0 : -1;
            3: t = (cur < lvl[res] || cur < n) ? 1 : -1;
            2: t = (res != 6 && res != 7) ? 2 :
                ((!ctrl[res-6] || lvl[res] > cur) ? 3 : -1);
            6: t = (lvl[5] > cur || n > cur) ? 0 : -1;
            default: t = 2;
        endcase
        core_u.issue(3'(op), 4'(res), 2'(n), d, pc, ok, flt);
        chk("req_ok", 32'(t < 0), {31'h0, ok});
        chk("req_fault", 32'(t >= 0), {31'h0, flt});
        if (t < 0 && op == 3 && d == 1)
            lvl[res] = n;
        if (t < 0 && op == 6)
            cur = n;
        if (t < 0 && op == 1)
            rdv = 32'(lvl[res]);
        if (t >= 0 && lvl[t] > cur)
            cur = lvl[t];
        if (t >= 0)
            stat = stat | (32'h1 << t);
        @(negedge clk);
        chk("exc_valid", 32'(t >= 0), {31'h0, exc_valid});
        if (t >= 0)
        begin
            chk("exc_type", 32'(t), {29'h0, exc_type});
            chk("exc_pc", {base[31:11], 3'(t), 2'(cur), 6'h00},
                exc_pc);
            chk("saved_pc", pc, saved_pc);
        end
        chk("rd_data", rdv, rd_data);
        chk("cur_level", 32'(cur), {30'h0, cur_level});
        chk("irq", 32'(|(stat & mask)), {31'h0, irq});
    end
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        reset_n = 1'b0;
        irq_in = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        void'($urandom(66809));
        foreach (lvl[i]) lvl[i] = 3;
        cur = 3;
        base = 32'h0;
        stat = 32'h0;
        mask = 32'h0;
        ctrl = 32'h0;
        rdv = 32'h0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        rd(32'h00, 32'h0, "ctrl_rst");
        rd(32'h04, 32'h0, "base_rst");
        rd(32'h08, 32'h0, "stat_rst");
        rd(32'h0C, 32'h0, "mask_rst");
        rd(32'h10, 32'h3, "level_rst");
        rd(32'h20, 32'h0, "unmapped");
        for (int r = 0; r < 16; r++) step(1, r, 0, 32'h1);
        base = $urandom;
        wr(32'h04, base);
        rd(32'h04, base, "base");
        wr(32'h10, 32'h0);
        rd(32'h10, 32'h3, "level_ro");
        // random mix; enables and mask reshuffled now and then
        for (int i = 0; i < 300; i++)
        begin
            if (i % 30 == 0)
            begin
                ctrl = $urandom % 4;
                mask = $urandom % 32;
                wr(32'h00, ctrl);
                wr(32'h0C, mask);
            end
            step(ops[$urandom % 7], $urandom % 16, $urandom % 4,
                ($urandom % 4 == 0) ? 32'h2 : 32'h1);
        end
        rd(32'h08, stat, "status");
        wr(32'h08, stat);
        stat = 32'h0;
        rd(32'h08, 32'h0, "status_clr");
        chk("irq_clr", 32'h0, {31'h0, irq});
        // outside interrupt is entered once the core is idle
        mask = 32'h10;
        wr(32'h0C, mask);
        @(posedge clk);
        irq_in <= 1'b1;
        @(posedge clk);
        irq_in <= 1'b0;
        for (int k = 0; k < 8 && exc_valid !== 1'b1; k++) @(negedge clk);
        if (lvl[4] > cur)
            cur = lvl[4];
        chk("irq_entry", 32'h1, {31'h0, exc_valid});
        chk("irq_type", 32'h4, {29'h0, exc_type});
        chk("irq_pc", {base[31:11], 3'h4, 2'(cur), 6'h00},
            exc_pc);
        chk("irq_level", 32'(cur), {30'h0, cur_level});
        chk("irq_pin", 32'h1, {31'h0, irq});
        wr(32'h08, 32'h10);
        // the clear lands at the last edge of the write; look once it settles
        @(negedge clk);
        chk("irq_off", 32'h0, {31'h0, irq});
        report_and_stop;
    end

    // a hang counts as a failure
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        report_and_stop;
    end
endmodule
